// ===== ebi_bus.sv
// External bus interface: strobe generation, address split, wait stretch.
// Behaviour
// RQ1: A bus clock is stretched as long as the wait input is held by the external party.
// RQ2: In 16-bit mode a separate high-byte write strobe marks writes to the upper byte.
// RQ3: The low four address bits sit on their own pins; only upper bits share the data lines. The code puts only bits 23:8 on them; bits 7:4 reach no pin.
// RQ4: Sequential code fetches inside one 16-byte block skip the address latch cycle.
// RQ5: Code read, data read and data write each have their own programmable clock count.
// RQ6: The external party latches upper address during the latch strobe, then uses lines as data.
`timescale 1ns/10ps
`default_nettype none

module ebi_bus
	import ebi_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	input wire logic bus16_in,
	input wire ebi_timing_type timing_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire ebi_req_type req_in,
	output logic done_out,
	output logic [DATA_W-1:0] rdata_out,
	output logic [LOW_ADDR_W-1:0] addr_low_out,
	output logic [DATA_W-1:0] ad_out,
	output logic ad_oe_out,
	input wire logic [DATA_W-1:0] ad_in,
	output logic addr_latch_out,
	output logic code_fetch_strobe_n_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	output logic high_byte_write_strobe_n_out,
	input wire logic wait_in
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic wait_meta_r, wait_r;
	logic [DATA_W-1:0] ad_meta_r, ad_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_meta_r <= 1'b0;
			wait_r <= 1'b0;
			ad_meta_r <= '0;
			ad_r <= '0;
		end else if (clk_en_in) begin
			wait_meta_r <= wait_in;
			wait_r <= wait_meta_r;
			ad_meta_r <= ad_in;
			ad_r <= ad_meta_r;
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	ebi_state_type state_r;
	ebi_req_type cur_r;
	logic [CNT_W-1:0] cnt_r;
	logic [ADDR_W-LOW_ADDR_W-1:0] code_blk_r;
	logic code_blk_ok_r;
	logic skip_ale;
	logic [CNT_W-1:0] clks_sel;

	// Read data lags the pins by the two synchroniser clocks, so a read
	// count below three returns the previous word; slow parts set more clocks.

	// Same block check for code fetch
	assign skip_ale = code_blk_ok_r && req_in.kind == EBI_CODE_READ
		&& req_in.addr[ADDR_W-1:LOW_ADDR_W] == code_blk_r;

	always_comb begin
		unique case (req_in.kind)
			EBI_CODE_READ: clks_sel = timing_in.code_clks;
			EBI_DATA_READ: clks_sel = timing_in.rd_clks;
			default: clks_sel = timing_in.wr_clks;
		endcase
	end

	assign req_ready_out = state_r == EBI_IDLE;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= EBI_IDLE;
			cur_r <= '0;
			cnt_r <= '0;
			done_out <= 1'b0;
		end else if (clk_en_in) begin
			done_out <= 1'b0;
			unique case (state_r)
				EBI_IDLE: begin
					if (req_valid_in) begin
						cur_r <= req_in;
						// RQ5 per-kind clock count
						cnt_r <= (clks_sel == '0) ? 4'h1 : clks_sel;
						// RQ4 sequential fetch skips latch
						if (skip_ale) begin
							state_r <= EBI_ACCESS;
						end else begin
							state_r <= EBI_ALE;
						end
					end
				end
				EBI_ALE: begin
					state_r <= EBI_ACCESS;
				end
				EBI_ACCESS: begin
					// RQ1 wait stretches the clock
					if (wait_r) begin
						cnt_r <= cnt_r;
					end else if (cnt_r == 4'h1) begin
						state_r <= EBI_IDLE;
						done_out <= 1'b1;
					end else begin
						cnt_r <= cnt_r - 4'h1;
					end
				end
			endcase
		end
	end

	// Code block tracker; any data cycle relatches the shared lines
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			code_blk_r <= '0;
			code_blk_ok_r <= 1'b0;
		end else if (clk_en_in && state_r == EBI_IDLE && req_valid_in) begin
			code_blk_r <= req_in.addr[ADDR_W-1:LOW_ADDR_W];
			code_blk_ok_r <= req_in.kind == EBI_CODE_READ;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= '0;
		end else if (clk_en_in && state_r == EBI_ACCESS && !wait_r && cnt_r == 4'h1
			&& cur_r.kind != EBI_DATA_WRITE) begin
			rdata_out <= ad_r;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	logic in_acc, is_wr;
	assign in_acc = state_r == EBI_ACCESS;
	assign is_wr = cur_r.kind == EBI_DATA_WRITE;

	// RQ3 dedicated low address pins
	assign addr_low_out = cur_r.addr[LOW_ADDR_W-1:0];
	// RQ6 upper address during latch, data after
	assign ad_out = (state_r == EBI_ALE) ?
		cur_r.addr[ADDR_W-1:ADDR_W-DATA_W] : cur_r.wdata;
	assign ad_oe_out = state_r == EBI_ALE || (in_acc && is_wr);
	assign addr_latch_out = state_r == EBI_ALE;
	assign code_fetch_strobe_n_out = !(in_acc && cur_r.kind == EBI_CODE_READ);
	assign read_strobe_n_out = !(in_acc && cur_r.kind == EBI_DATA_READ);
	assign write_strobe_n_out = !(in_acc && is_wr && (cur_r.byte_en[0] || !bus16_in));
	// RQ2 high byte strobe in 16-bit mode
	assign high_byte_write_strobe_n_out = !(in_acc && is_wr && bus16_in && cur_r.byte_en[1]);

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	a_wait_holds_access: assert property (in_acc && wait_r && clk_en_in |=> in_acc) // RQ1
		else $error("access ended while wait held");
	a_high_strobe_mode: assert property (!high_byte_write_strobe_n_out |-> bus16_in && is_wr) // RQ2
		else $error("high byte strobe outside 16-bit write");
	a_low_addr_pins: assert property (addr_low_out == cur_r.addr[3:0]) // RQ3
		else $error("low address pins wrong");
	a_latch_upper_addr: assert property ( // RQ3
		addr_latch_out |-> ad_out == cur_r.addr[ADDR_W-1:ADDR_W-DATA_W])
		else $error("shared lines do not carry upper address in latch cycle");
	a_seq_fetch_skip: assert property (req_ready_out && req_valid_in && skip_ale && clk_en_in
		|=> in_acc) // RQ4
		else $error("sequential fetch issued latch cycle");
	a_new_block_latch: assert property ( // RQ4
		req_ready_out && req_valid_in && clk_en_in && !skip_ale |=> addr_latch_out)
		else $error("new block fetch or data cycle without latch cycle");

	// ****************************************
	// Access length sequences
	// ****************************************
	// Take of a three-clock cycle that needs a latch cycle
	sequence s_take_three;
		req_ready_out && req_valid_in && clk_en_in && clks_sel == 4'h3 && !skip_ale;
	endsequence
	// Latch clock plus three access clocks, none stretched
	sequence s_run_clean;
		(clk_en_in && !wait_r)[*4];
	endsequence

	a_access_length: assert property (s_take_three ##1 s_run_clean |=> done_out) // RQ5
		else $error("access length does not match programmed count");
	a_done_single: assert property (done_out && clk_en_in |=> !done_out) // RQ5
		else $error("done held longer than one clock");
	a_wait_freezes_cnt: assert property ( // RQ1
		in_acc && wait_r && clk_en_in |=> $stable(cnt_r))
		else $error("clock count moved while wait held");
	a_latch_drives: assert property (addr_latch_out |-> ad_oe_out) // RQ6
		else $error("upper address not driven during latch");
	a_fetch_lines_free: assert property ( // RQ6
		!code_fetch_strobe_n_out |-> !ad_oe_out && read_strobe_n_out
		&& write_strobe_n_out && high_byte_write_strobe_n_out)
		else $error("shared lines driven or other strobe during code fetch");

endmodule : ebi_bus

`default_nettype wire

// ===== ebi_bus_bench.sv
// Testbench for the external bus interface.
`timescale 1ns/10ps
`default_nettype none
module ebi_bus_bench import ebi_pkg::*;;
	logic clk_in = 0, reset_n_in = 0, bus16_in = 1, req_valid_in = 0, hold_in = 0;
	ebi_timing_type timing_in = '{4'h3, 4'h4, 4'h2};
	ebi_req_type req_in = '0;
	logic req_ready_out, done_out, ad_oe_out, addr_latch_out, wait_in;
	logic cf_n, rd_n, wr_n, hb_n;
	logic [15:0] rdata_out, ad_out, ad_in, wd_seen;
	int n_oe;
	logic [3:0] addr_low_out, low_seen;
	int n_fail = 0, checked = 0, n_lat, n_str, n_hi;
	always #2 clk_in = ~clk_in;
	ebi_bus u_ebi_bus(.clk_in, .reset_n_in, .clk_en_in(1'b1), .bus16_in, .timing_in,
		.req_valid_in, .req_ready_out, .req_in, .done_out, .rdata_out, .addr_low_out,
		.ad_out, .ad_oe_out, .ad_in, .addr_latch_out, .code_fetch_strobe_n_out(cf_n),
		.read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n),
		.high_byte_write_strobe_n_out(hb_n), .wait_in);
	ebi_mem u_ebi_mem(.clk_in, .bus_in(ad_out), .latch_in(addr_latch_out),
		.rd_n_in(rd_n & cf_n), .hold_in, .ad_out(ad_in), .wait_out(wait_in));
	// ****
	// Shared tasks
	// ****
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic xfer(input ebi_kind_type k, input logic [23:0] a, input logic [1:0] be,
		input int hold);
		n_lat = 0;
		n_str = 0;
		n_hi = 0;
		n_oe = 0;
		req_in = '{k, a, 16'hc3a5, be};
		req_valid_in = 1;
		hold_in = hold > 0;
		@(negedge clk_in);
		req_valid_in = 0;
		for (int i = 0; i < 99 && done_out !== 1'b1; i++) begin
			n_lat += addr_latch_out;
			n_hi += !hb_n;
			n_oe += ad_oe_out;
			if (!(wr_n & hb_n)) begin
				wd_seen = ad_out;
			end
			if (!(cf_n & rd_n & wr_n & hb_n)) begin
				n_str++;
				low_seen = addr_low_out;
			end
			hold_in = i + 1 < hold;
			@(negedge clk_in);
		end
		check("done", done_out, 1);
		@(negedge clk_in);
	endtask : xfer
	task automatic t_read;
		xfer(EBI_DATA_READ, 24'h12a5b0, 2'b11, 0);
		check("latch", n_lat, 1);
		check("rd clks", n_str, 4);
		check("rdata", rdata_out, 16'hed5a);
		check("read oe", n_oe, 1);
		xfer(EBI_DATA_READ, 24'h12a5b0, 2'b11, 3);
		check("stretch", n_str > 4, 1);
	endtask : t_read
	task automatic t_code;
		xfer(EBI_CODE_READ, 24'h000300, 2'b11, 0);
		check("code clks", n_str, 3);
		xfer(EBI_CODE_READ, 24'h00030e, 2'b11, 0);
		check("no latch", n_lat, 0);
		check("low addr", low_seen, 4'he);
		xfer(EBI_CODE_READ, 24'h000310, 2'b11, 0);
		check("new block", n_lat, 1);
	endtask : t_code
	task automatic t_write;
		xfer(EBI_DATA_WRITE, 24'h000400, 2'b10, 0);
		check("wr clks", n_str, 2);
		check("high strobe", n_hi, 2);
		check("write oe", n_oe, 3);
		check("write data", wd_seen, 16'hc3a5);
		bus16_in = 0;
		xfer(EBI_DATA_WRITE, 24'h000402, 2'b11, 0);
		check("8 bit high", n_hi, 0);
	endtask : t_write
	task automatic test_done;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (12) @(negedge clk_in);
		reset_n_in = 1;
		check("idle", {req_ready_out, cf_n, rd_n, wr_n, hb_n, addr_latch_out}, 6'h3e);
		t_read();
		t_code();
		t_write();
		test_done();
	end
	// Whole run is well under 300 cycles
	initial begin
		#10000;
		n_fail++;
		test_done();
	end
endmodule : ebi_bus_bench
`default_nettype wire

// ===== ebi_mem.sv
// Partner model: external memory on the multiplexed bus.
`timescale 1ns/10ps
`default_nettype none
module ebi_mem
	import ebi_pkg::*;
(
	input wire logic clk_in,
	input wire logic [DATA_W-1:0] bus_in,
	input wire logic latch_in,
	input wire logic rd_n_in,
	input wire logic hold_in,
	output logic [DATA_W-1:0] ad_out,
	output logic wait_out
);
	logic [DATA_W-1:0] hi_r;
	initial ad_out = '0;
	always @(posedge clk_in) begin
		if (latch_in) begin
			hi_r <= bus_in;
		end
	end
	always @(posedge clk_in) begin
		ad_out <= rd_n_in ? ~ad_out : ~hi_r;
	end
	assign wait_out = hold_in;
endmodule : ebi_mem
`default_nettype wire

// ===== ebi_pkg.sv
// Package for the external bus interface: constants, types and states.
package ebi_pkg;

	// ****************************************
	// Widths and timing
	// ****************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int LOW_ADDR_W = 4;
	localparam int CNT_W = 4;
	localparam logic [3:0] CODE_CLKS_RST = 4'h2;
	localparam logic [3:0] RD_CLKS_RST = 4'h2;
	localparam logic [3:0] WR_CLKS_RST = 4'h2;
	localparam logic [3:0] ALE_CLKS = 4'h1;

	typedef enum logic [1:0] {
		EBI_CODE_READ,
		EBI_DATA_READ,
		EBI_DATA_WRITE
	} ebi_kind_type;

	typedef enum {
		EBI_IDLE,
		EBI_ALE,
		EBI_ACCESS
	} ebi_state_type;

	typedef struct packed {
		ebi_kind_type kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] byte_en;
	} ebi_req_type;

	typedef struct packed {
		logic [CNT_W-1:0] code_clks;
		logic [CNT_W-1:0] rd_clks;
		logic [CNT_W-1:0] wr_clks;
	} ebi_timing_type;

endpackage : ebi_pkg
